// ==== design/edh_stat_bank.sv ====
// status register bank and status pin selectors
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Selector code 00000 shows horizontal blanking, or horizontal sync under consumer timing.
// - Code 00001 shows vertical blanking, or vertical sync under consumer timing.
// - Code 00010 shows the field bit, or display enable under consumer timing.
// - Codes 00011, 00100, 00101 show lock, luma/SD ancillary and chroma ancillary indication.
// - Codes 00110, 00111, 01001, 01010, 01011 show data error, video error, EDH found, carrier, rate.
// - Code 01000 and codes 01100 to 11111 are reserved and drive the pin low.
// - Pin two selector sits in bits 14-10 of select register A and resets to 2.
// - Pin one selector is bits 9-5 (reset 1), pin zero selector bits 4-0 (reset 0).
// - Pin five selector sits in bits 14-10 of select register B and resets to 6.
// - Received-EDH register shows packet found at bit 15 and ancillary flags at 14-10, reset zero.
// - Received-EDH register holds full-field flags at 9-5 and active-picture flags at 4-0.
// - Format register shows full-field CRC valid at bit 15 and picture CRC valid at bit 14.
// - Detected video standard reads at bits 13-8 and resets to 29.
// - Chroma format code reads at bits 7-4, luma code at 3-0, both reset to 15.
// - Consumer timing select 0 gives field/vertical/horizontal timing, 1 gives sync/enable.
module esp_edh_stat_bank
  import esp_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // register port
  input  wire logic [9:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [15:0] regRdData,
  // receive path status, same clock
  input  wire esp_ind_t    indications,
  input  wire esp_fmt_t    formatStatus,
  // pins
  output logic      [5:0]  statusPin,
  output logic             irq
);

  localparam int PINS = 6;

  logic [4:0]        pinSel [PINS];
  logic              consumerTimingSelect;
  logic [14:0]       edhRxFlags;
  logic              edhPacketFound;
  logic [14:0]       edhGenFlags;
  logic [15:0]       formatReg;
  logic [IRQ_W-1:0]  irqStatus;
  logic [IRQ_W-1:0]  irqMask;
  logic [IRQ_W-1:0]  irqEvent;
  logic              lockPrev;
  wire  [PINS-1:0]   next_statusPin;
  logic [15:0]       next_regRdData;

  // selector registers; pins three and four keep their reset codes and are read-only in select register B
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pinSel[0] <= SEL_PIN0_RST;
      pinSel[1] <= SEL_PIN1_RST;
      pinSel[2] <= SEL_PIN2_RST;
      pinSel[3] <= SEL_PIN3_RST;
      pinSel[4] <= SEL_PIN4_RST;
      pinSel[5] <= SEL_PIN5_RST;
    end
    else if (regWrite && regAddr == REG_PIN_SEL_A)
    begin
      pinSel[2] <= regWrData[SEL_HI_POS +: SEL_W];
      pinSel[1] <= regWrData[SEL_MID_POS +: SEL_W];
      pinSel[0] <= regWrData[SEL_LO_POS +: SEL_W];
    end
    else if (regWrite && regAddr == REG_PIN_SEL_B)
    begin
      pinSel[5] <= regWrData[SEL_HI_POS +: SEL_W];
    end
  end

  // timing format select
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      consumerTimingSelect <= 1'b0;
    else if (regWrite && regAddr == REG_TIMING)
      consumerTimingSelect <= regWrData[0];
  end

  // received flags only move on a decoded packet so reads stay stable
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      edhRxFlags     <= EDH_RX_RST;
      edhPacketFound <= 1'b0;
      edhGenFlags    <= EDH_GEN_RST;
    end
    else if (formatStatus.edhValid)
    begin
      edhRxFlags     <= formatStatus.edhRxFlags;
      edhPacketFound <= 1'b1;
      edhGenFlags    <= formatStatus.edhGenFlags;
    end
  end

  // format and crc status
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      formatReg <= {2'b00, STD_RST, FMT_RST, FMT_RST};
    end
    else
    begin
      formatReg[FULLFIELD_CRC_VALID_POS]          <= formatStatus.fullfieldCrcValid;
      formatReg[PICTURE_CRC_VALID_POS]          <= formatStatus.pictureCrcValid;
      formatReg[STD_POS +: 6]          <= formatStatus.detectedVideoStandard;
      formatReg[CHROMA_FMT_POS +: 4]   <= formatStatus.chromaFormatCode;
      formatReg[LUMA_FMT_POS +: 4]     <= formatStatus.lumaFormatCode;
    end
  end

  // interrupt events
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      lockPrev <= 1'b0;
    else
      lockPrev <= indications.receiverLockFlag;
  end

  always_comb
  begin
    irqEvent               = '0;
    irqEvent[IRQ_EDH_PKT]  = formatStatus.edhValid;
    irqEvent[IRQ_LOCK_CHG] = lockPrev != indications.receiverLockFlag;
    irqEvent[IRQ_DATA_ERR] = indications.dataError;
    irqEvent[IRQ_VID_ERR]  = indications.videoError;
  end

  // set wins over a same-cycle write-one clear
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      irqStatus <= '0;
    else if (regWrite && regAddr == REG_IRQ_STATUS)
      irqStatus <= (irqStatus & ~regWrData[IRQ_W-1:0]) | irqEvent;
    else
      irqStatus <= irqStatus | irqEvent;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      irqMask <= '0;
    else if (regWrite && regAddr == REG_IRQ_MASK)
      irqMask <= regWrData[IRQ_W-1:0];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= |(irqStatus & irqMask);
  end

  // per-pin selector decode
  genvar p;
  generate
    for (p = 0; p < PINS; p++)
    begin : g_pin
      // one local value per pin keeps each bit to a single driver
      logic pinVal;
      always_comb
      begin
        case (pinSel[p])
          SEL_HORIZ:    pinVal = consumerTimingSelect ?
                          indications.hSync : indications.hBlank;
          SEL_VERT:     pinVal = consumerTimingSelect ?
                          indications.vSync : indications.vBlank;
          SEL_FIELD:    pinVal = consumerTimingSelect ?
                          indications.displayEnable :
                          indications.fieldBit;
          SEL_LOCK:     pinVal = indications.receiverLockFlag;
          SEL_LUMA_ANC: pinVal = indications.lumaAncIndication;
          SEL_CHR_ANC:  pinVal = indications.chromaAncIndication;
          SEL_DATA_ERR: pinVal = indications.dataError;
          SEL_VID_ERR:  pinVal = indications.videoError;
          SEL_EDH_DET:  pinVal = edhPacketFound;
          SEL_CARRIER:  pinVal = indications.carrierDetect;
          SEL_RATE:     pinVal = indications.detectedRateFlag;
          default:      pinVal = 1'b0;
        endcase
      end
      assign next_statusPin[p] = pinVal;
    end
  endgenerate

  // pins are registered, one cycle behind the indications
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      statusPin <= '0;
    else
      statusPin <= next_statusPin;
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    case (regAddr)
      REG_EDH_RX:     next_regRdData = {edhPacketFound, edhRxFlags};
      REG_EDH_GEN:    next_regRdData = {1'b0, edhGenFlags};
      REG_FORMAT:     next_regRdData = formatReg;
      REG_PIN_SEL_A:  next_regRdData = {1'b0, pinSel[2], pinSel[1], pinSel[0]};
      REG_PIN_SEL_B:  next_regRdData = {1'b0, pinSel[5], pinSel[4], pinSel[3]};
      REG_IRQ_STATUS: next_regRdData = {12'h000, irqStatus};
      REG_IRQ_MASK:   next_regRdData = {12'h000, irqMask};
      REG_TIMING:     next_regRdData = {15'h0000, consumerTimingSelect};
      default:        next_regRdData = 16'h0000;
    endcase
  end

  // data stand for exactly the cycle after the strobe
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      regRdData <= 16'h0000;
    else if (regRead)
      regRdData <= next_regRdData;
    else
      regRdData <= 16'h0000;
  end

endmodule // esp_edh_stat_bank
`default_nettype wire

// ==== design/edh_stat_pkg.sv ====
// package: register map, field layout, reset values and types for the status bank
package esp_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] REG_EDH_RX     = 10'h004;
  localparam logic [9:0] REG_EDH_GEN    = 10'h005;
  localparam logic [9:0] REG_FORMAT     = 10'h006;
  localparam logic [9:0] REG_PIN_SEL_A  = 10'h008;
  localparam logic [9:0] REG_PIN_SEL_B  = 10'h009;
  localparam logic [9:0] REG_IRQ_STATUS = 10'h030;
  localparam logic [9:0] REG_IRQ_MASK   = 10'h031;
  localparam logic [9:0] REG_TIMING     = 10'h032;

  // selector field positions (low bit of each five-bit field)
  localparam int SEL_W        = 5;
  localparam int SEL_HI_POS   = 10;
  localparam int SEL_MID_POS  = 5;
  localparam int SEL_LO_POS   = 0;

  // selector reset codes
  localparam logic [4:0] SEL_PIN0_RST = 5'h00;
  localparam logic [4:0] SEL_PIN1_RST = 5'h01;
  localparam logic [4:0] SEL_PIN2_RST = 5'h02;
  localparam logic [4:0] SEL_PIN3_RST = 5'h03;
  localparam logic [4:0] SEL_PIN4_RST = 5'h04;
  localparam logic [4:0] SEL_PIN5_RST = 5'h06;

  // selector encoding
  localparam logic [4:0] SEL_HORIZ    = 5'h00;
  localparam logic [4:0] SEL_VERT     = 5'h01;
  localparam logic [4:0] SEL_FIELD    = 5'h02;
  localparam logic [4:0] SEL_LOCK     = 5'h03;
  localparam logic [4:0] SEL_LUMA_ANC = 5'h04;
  localparam logic [4:0] SEL_CHR_ANC  = 5'h05;
  localparam logic [4:0] SEL_DATA_ERR = 5'h06;
  localparam logic [4:0] SEL_VID_ERR  = 5'h07;
  localparam logic [4:0] SEL_EDH_DET  = 5'h09;
  localparam logic [4:0] SEL_CARRIER  = 5'h0A;
  localparam logic [4:0] SEL_RATE     = 5'h0B;

  // status field positions and resets
  localparam int          EDH_FOUND_POS   = 15;
  localparam int          FULLFIELD_CRC_VALID_POS    = 15;
  localparam int          PICTURE_CRC_VALID_POS    = 14;
  localparam int          STD_POS         = 8;
  localparam int          CHROMA_FMT_POS  = 4;
  localparam int          LUMA_FMT_POS    = 0;
  localparam logic [14:0] EDH_RX_RST      = 15'h0000;
  localparam logic [14:0] EDH_GEN_RST     = 15'h4210;
  localparam logic [5:0]  STD_RST         = 6'h1D;
  localparam logic [3:0]  FMT_RST         = 4'hF;

  // interrupt status bit positions
  localparam int IRQ_EDH_PKT  = 0;
  localparam int IRQ_LOCK_CHG = 1;
  localparam int IRQ_DATA_ERR = 2;
  localparam int IRQ_VID_ERR  = 3;
  localparam int IRQ_W        = 4;

  // video timing and indications from the receive path
  typedef struct packed {
    logic hBlank;
    logic vBlank;
    logic fieldBit;
    logic hSync;
    logic vSync;
    logic displayEnable;
    logic receiverLockFlag;
    logic lumaAncIndication;
    logic chromaAncIndication;
    logic dataError;
    logic videoError;
    logic carrierDetect;
    logic detectedRateFlag;
  } esp_ind_t;

  // decoded packet and format status from the receive path
  typedef struct packed {
    logic        edhValid;
    logic [14:0] edhRxFlags;
    logic [14:0] edhGenFlags;
    logic        fullfieldCrcValid;
    logic        pictureCrcValid;
    logic [5:0]  detectedVideoStandard;
    logic [3:0]  chromaFormatCode;
    logic [3:0]  lumaFormatCode;
  } esp_fmt_t;

endpackage

// ==== test/edh_stat_asserts.sv ====
// checker for the status bank register port and pins
`timescale 1ns/100ps
`default_nettype none
module esp_edh_stat_asserts
  import esp_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // register port
  input wire logic [9:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [15:0] regRdData,
  // status inputs and pins
  input wire esp_ind_t    indications,
  input wire esp_fmt_t    formatStatus,
  input wire logic [5:0]  statusPin,
  input wire logic        irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] fmtWord;
  logic        wrA;
  logic        wrB;
  assign fmtWord = {formatStatus.fullfieldCrcValid,
    formatStatus.pictureCrcValid, formatStatus.detectedVideoStandard,
    formatStatus.chromaFormatCode, formatStatus.lumaFormatCode};
  assign wrA = regWrite && regAddr == REG_PIN_SEL_A;
  assign wrB = regWrite && regAddr == REG_PIN_SEL_B;
  AST_RD_IDLE: assert property (!regRead |=> regRdData == 16'h0000)
    else $error("read data not zero outside a read");
  AST_FORMAT: assert property (regRead && regAddr == REG_FORMAT &&
    $stable(fmtWord) && $past(fmtWord) == $past(fmtWord, 2)
    |=> regRdData == $past(fmtWord))
    else $error("format register word wrong");
  AST_RESERVED: assert property (wrA && regWrData[14:0] == 15'h7FFF
    ##1 !wrA |=> statusPin[2:0] == 3'b000)
    else $error("reserved code drove a pin");
  AST_LOCK: assert property (wrA && regWrData[4:0] == SEL_LOCK
    ##1 !wrA |=> statusPin[0] == $past(indications.receiverLockFlag))
    else $error("pin zero not lock");
  AST_PIN5: assert property (wrB && regWrData[14:10] == SEL_DATA_ERR
    ##1 !wrB |=> statusPin[5] == $past(indications.dataError))
    else $error("pin five not data error");
  AST_READBACK: assert property (wrA ##1 !regWrite
    ##1 (regRead && regAddr == REG_PIN_SEL_A)
    |=> regRdData == ($past(regWrData, 3) & 16'h7FFF))
    else $error("select register readback wrong");
  AST_RX_FOUND: assert property (formatStatus.edhValid
    ##1 !formatStatus.edhValid ##1 (regRead && regAddr == REG_EDH_RX)
    |=> regRdData == {1'b1, $past(formatStatus.edhRxFlags, 3)})
    else $error("received flags not loaded");
  AST_MASK_OFF: assert property (regWrite && regAddr == REG_IRQ_MASK &&
    regWrData[3:0] == 4'h0 |-> ##2 !irq)
    else $error("irq high with all masked");
  CVR_EDH: cover property (formatStatus.edhValid);
  CVR_IRQ: cover property (irq);
  CVR_WRRD: cover property (wrA ##2 regRead);
endmodule // esp_edh_stat_asserts
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the status bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb;
  import esp_pkg::*;
  logic        sys_clk;
  logic        reset_n;
  logic [9:0]  regAddr;
  logic [15:0] regWrData;
  logic        regWrite;
  logic        regRead;
  logic [15:0] regRdData;
  esp_ind_t    indications;
  esp_fmt_t    formatStatus;
  logic [5:0]  statusPin;
  logic        irq;
  int          fails = 0;
  int          n_compared = 0;
  logic [15:0] got;
  int          cd [13] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 11, 0, 1, 2};
  int          bt [13] = '{12, 11, 10, 6, 5, 4, 3, 2, 1, 0, 9, 8, 7};
  int          rs [3] = '{8, 12, 31};
  esp_edh_stat_bank dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .indications(indications),
    .formatStatus(formatStatus), .statusPin(statusPin), .irq(irq));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge sys_clk);
    regWrite  <= 1'b0;
  endtask
  task automatic rdc(input logic [9:0] a, input logic [15:0] e, string nm);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    got = regRdData;
    `CHK(nm, e, got)
  endtask
  // pins and irq lag the cause by one edge
  task automatic settle;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    close_out;
  end
  initial
  begin
    {regAddr, regWrData, regWrite, regRead} = '0;
    indications = '0;
    formatStatus = '{1'b0, 15'h5555, 15'h2AAA, 1'b0, 1'b0, 6'h1D, 4'hF, 4'hF};
    reset_n = 1'b0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    rdc(REG_EDH_RX, 16'h0000, "rx reset");
    rdc(REG_EDH_GEN, 16'h4210, "gen reset");
    rdc(REG_FORMAT, 16'h1DFF, "format reset");
    rdc(REG_PIN_SEL_A, 16'h0820, "sel a reset");
    rdc(REG_PIN_SEL_B, 16'h1883, "sel b reset");
    wr(REG_PIN_SEL_A, 16'hFFFF);
    rdc(REG_PIN_SEL_A, 16'h7FFF, "sel a fields");
    wr(REG_PIN_SEL_B, 16'hFFFF);
    rdc(REG_PIN_SEL_B, 16'h7C83, "sel b fields");
    $display("test registers done");
    for (int i = 0; i < 3; i++)
    begin
      wr(REG_PIN_SEL_A, {1'b0, {3{rs[i][4:0]}}});
      wr(REG_PIN_SEL_B, {1'b0, rs[i][4:0], 10'h083});
      indications <= '1;
      settle;
      `CHK("reserved pins", 4'h0, {statusPin[5], statusPin[2:0]})
    end
    for (int i = 0; i < 13; i++)
      for (int v = 0; v < 2; v++)
      begin
        wr(REG_TIMING, {15'h0000, i > 9});
        wr(REG_PIN_SEL_A, 16'(cd[i]));
        indications <= esp_ind_t'(v ? ~(13'h1 << bt[i]) : 13'h1 << bt[i]);
        settle;
        `CHK("pin zero", 1'(v == 0), statusPin[0])
      end
    wr(REG_PIN_SEL_B, 16'h1800);
    indications <= esp_ind_t'(13'h0008);
    settle;
    `CHK("pin five", 1'b1, statusPin[5])
    rdc(REG_TIMING, 16'h0001, "timing select");
    $display("test pins done");
    @(posedge sys_clk);
    formatStatus <= '{1'b0, 15'h5555, 15'h2AAA, 1'b1, 1'b1, 6'h2A, 4'h3, 4'h5};
    wr(REG_FORMAT, 16'h0000);
    rdc(REG_FORMAT, 16'hEA35, "format live");
    rdc(10'h007, 16'h0000, "unmapped");
    rdc(REG_EDH_RX, 16'h0000, "rx no packet");
    @(posedge sys_clk);
    formatStatus.edhValid <= 1'b1;
    @(posedge sys_clk);
    formatStatus.edhValid <= 1'b0;
    formatStatus.edhRxFlags <= 15'h0F0F;
    rdc(REG_EDH_RX, 16'hD555, "rx packet");
    rdc(REG_EDH_GEN, 16'h2AAA, "gen packet");
    wr(REG_EDH_RX, 16'h0000);
    rdc(REG_EDH_RX, 16'hD555, "rx held");
    wr(REG_PIN_SEL_A, 16'h0009);
    settle;
    `CHK("edh pin", 1'b1, statusPin[0])
    $display("test edh done");
    wr(REG_IRQ_MASK, 16'h0000);
    settle;
    `CHK("irq masked", 1'b0, irq)
    wr(REG_IRQ_MASK, 16'h0001);
    settle;
    `CHK("irq raised", 1'b1, irq)
    wr(REG_IRQ_STATUS, 16'h0001);
    settle;
    `CHK("irq cleared", 1'b0, irq)
    rdc(REG_IRQ_MASK, 16'h0001, "irq mask");
    rdc(REG_IRQ_STATUS, 16'h000E, "irq status");
    $display("test irq done");
    close_out;
  end
endmodule // tb
bind esp_edh_stat_bank esp_edh_stat_asserts chk (.sys_clk(sys_clk),
  .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .indications(indications), .formatStatus(formatStatus),
  .statusPin(statusPin), .irq(irq));
`default_nettype wire
